//--- common/rsm_pkg.sv
// Constants, register map and lane mapping for the reset, strap and lane swap pin block
package rsm_pkg;

  // ----------------------------------------------------------------
  // Clock and sizes
  // ----------------------------------------------------------------
  localparam int CLK_SYS_HZ = 10_000_000;
  localparam int NUM_PAIRS  = 8;
  localparam int NUM_LANES  = 4;
  localparam int NUM_TP     = 8;
  localparam int STRAP_WAIT = 2;    // Synchroniser depth before the straps are valid

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_TP_SEL   = 8'h04;
  localparam logic [7:0]  REG_TP2_DIV  = 8'h08;
  localparam logic [7:0]  REG_STATUS   = 8'h0C;
  localparam int          SWAP_LSB     = 0;      // Four-bit swap code, low two bits used
  localparam int          LANES_LSB    = 4;      // Three-bit count of active lanes
  localparam logic [15:0] CTRL_MASK    = 16'h007F;
  localparam logic [15:0] CTRL_RST     = 16'h0040;
  localparam logic [15:0] TP_SEL_RST   = 16'h0000;
  localparam logic [15:0] TP_SEL_DEBUG = 16'h5555;
  localparam int          STAT_DONE    = 8;

  // ----------------------------------------------------------------
  // Test point selections and strap codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TP_FLOAT    = 2'h0;
  localparam logic [1:0] TP_FUNC     = 2'h1;
  localparam logic [1:0] TP_LOW      = 2'h2;
  localparam logic [1:0] TP_HIGH     = 2'h3;
  localparam logic [2:0] STRAP_QUIET = 3'h0;
  localparam logic [2:0] STRAP_DEBUG = 3'h2;

  // ----------------------------------------------------------------
  // Debug clock rates and the divider half periods derived from them
  // ----------------------------------------------------------------
  localparam int TP0_HZ     = 60_000_000;
  localparam int TP1_HZ     = 30_000_000;
  localparam int TP7_HZ     = 7_500_000;
  localparam int TP2_MIN_HZ = 700_000;
  localparam int TP2_MAX_HZ = 22_500_000;

  // Longest half period whose rate does not fall below the target, never below one cycle
  function automatic int half_of(int hz);
    int h;
    h = CLK_SYS_HZ / (2 * hz);
    return (h < 1) ? 1 : h;
  endfunction

  localparam logic [7:0] TP0_HALF    = 8'(half_of(TP0_HZ));
  localparam logic [7:0] TP1_HALF    = 8'(half_of(TP1_HZ));
  localparam logic [7:0] TP7_HALF    = 8'(half_of(TP7_HZ));
  localparam logic [7:0] TP2_HALF_LO = 8'(half_of(TP2_MAX_HZ));
  localparam logic [7:0] TP2_HALF_HI = 8'(half_of(TP2_MIN_HZ));

  // Source pair (A=0 .. H=7) for an array lane under a swap code
  function automatic logic [2:0] lane_src(logic [1:0] code, logic [1:0] lane);
    logic [11:0] map;
    case (code)
      2'h0:    map = {3'd4, 3'd5, 3'd2, 3'd3};  // D,C,F,E
      2'h2:    map = {3'd3, 3'd2, 3'd5, 3'd4};  // E,F,C,D
      2'h1:    map = {3'd0, 3'd1, 3'd6, 3'd7};  // H,G,B,A
      default: map = {3'd7, 3'd6, 3'd1, 3'd0};  // A,B,G,H
    endcase
    return map[lane * 3 +: 3];
  endfunction

endpackage

//--- logic/rsm_strap_capture.sv
// Test point strap synchroniser and one-time capture after reset release
`timescale 1ns/1ps
module rsm_strap_capture
  import rsm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Strap pins
  input  wire logic [7:0] tp_pins,
  // Captured strap
  output logic      [7:0] strap_ff,
  output logic            done_ff
);

  logic [7:0] sync1_ff;
  logic [7:0] nxt_sync1;
  logic [7:0] sync2_ff;
  logic [7:0] nxt_sync2;
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  logic [7:0] nxt_strap;
  logic       nxt_done;

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Straps are taken once the synchroniser holds post-release samples
  always_comb begin
    nxt_sync1 = tp_pins;
    nxt_sync2 = sync1_ff;
    nxt_wait  = wait_ff;
    nxt_strap = strap_ff;
    nxt_done  = done_ff;
    if (!done_ff) begin
      if (wait_ff == 2'(STRAP_WAIT)) begin
        nxt_strap = sync2_ff;
        nxt_done  = 1'b1;      // Held until the next reset
      end else begin
        nxt_wait = wait_ff + 2'd1;
      end
    end
  end

  // Only reset clears the capture, so later pin changes are ignored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      wait_ff  <= 2'h0;
      strap_ff <= 8'h00;
      done_ff  <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      wait_ff  <= nxt_wait;
      strap_ff <= nxt_strap;
      done_ff  <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_STRAP_HOLD: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    done_ff |=> (done_ff && $stable(strap_ff)))
    else $error("strap value changed after capture");

endmodule

//--- logic/rsm_pin_mux.sv
// Flash pin release, test point straps and outputs, and array lane swap
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rsm_pin_mux
  import rsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Flash signals from the core
  input  wire logic        flash_clk_core,
  input  wire logic        flash_out_core,
  input  wire logic        flash_sel0_core,
  input  wire logic        flash_sel1_core,
  // Flash pins
  output logic             flash_serial_clock_o,
  output logic             flash_serial_clock_oe_n,
  output logic             flash_serial_out_o,
  output logic             flash_serial_out_oe_n,
  output logic             flash_select_primary_o,
  output logic             flash_select_primary_oe_n,
  output logic             flash_select_secondary_o,
  output logic             flash_select_secondary_oe_n,
  // Test point pins
  input  wire logic [7:0]  test_point_bus_i,
  output logic      [7:0]  test_point_bus_o,
  output logic      [7:0]  test_point_bus_oe_n,
  output logic      [3:0]  mode_option,
  // Write lane pairs from the formatter
  input  wire logic [7:0]  fast_write_lane_pair_p,
  input  wire logic [7:0]  fast_write_lane_pair_n,
  input  wire logic        array_ctl_core,
  // Mirror array link
  input  wire logic        array_link_clk,
  output logic      [3:0]  mirror_array_lane_p,
  output logic      [3:0]  mirror_array_lane_n,
  output logic             mirror_array_hs_clk,
  output logic             mirror_array_ctl
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [15:0] tp_sel_ff, nxt_tp_sel;
  logic [7:0]  tp2_div_ff, nxt_tp2_div;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        done_seen_ff, nxt_done_seen;
  logic [3:0]  mode_ff, nxt_mode;
  logic [7:0]  strap_val;
  logic        strap_done;
  logic        strap_load;
  logic [1:0]  swap_code;
  logic [2:0]  lane_lim;
  logic [3:0]  fl_out_ff, nxt_fl_out;
  logic [3:0]  fl_oe_n_ff, nxt_fl_oe_n;
  logic        lk_s1_ff, lk_s2_ff, lk_s3_ff;
  logic        hs_edge;
  logic        ls_rise;
  logic [3:0]  lane_p_ff, nxt_lane_p;
  logic [3:0]  lane_n_ff, nxt_lane_n;
  logic        hs_clk_ff, nxt_hs_clk;
  logic        ctl_ff, nxt_ctl;
  logic [7:0]  div_cnt_ff [4];
  logic [7:0]  nxt_div_cnt [4];
  logic [3:0]  div_ph_ff, nxt_div_ph;
  logic [7:0]  div_half [4];
  logic [7:0]  func_lvl;
  logic [7:0]  tp_o_ff, nxt_tp_o;
  logic [7:0]  tp_oe_n_ff, nxt_tp_oe_n;
  logic        exp_p0;
  logic        exp_n0;

  // Strap capture runs in its own small module
  rsm_strap_capture rsm_strap_capture_inst (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .tp_pins  (test_point_bus_i),
    .strap_ff (strap_val),
    .done_ff  (strap_done)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  assign strap_load = strap_done & ~done_seen_ff;
  assign swap_code  = ctrl_ff[SWAP_LSB +: 2];  // Upper code digit ignored
  assign lane_lim   = (ctrl_ff[LANES_LSB +: 3] > 3'(NUM_LANES)) ? 3'(NUM_LANES)
                                                                : ctrl_ff[LANES_LSB +: 3];

  // Writes, strap defaults and registered read data
  always_comb begin
    nxt_ctrl      = ctrl_ff;
    nxt_tp_sel    = tp_sel_ff;
    nxt_tp2_div   = tp2_div_ff;
    nxt_rdata     = 16'h0000;
    nxt_done_seen = strap_done;
    nxt_mode      = mode_ff;
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        nxt_ctrl = reg_wdata & CTRL_MASK;
      end else if (reg_addr == REG_TP_SEL) begin
        nxt_tp_sel = reg_wdata;
      end else if (reg_addr == REG_TP2_DIV) begin
        if (reg_wdata[7:0] < TP2_HALF_LO) begin
          nxt_tp2_div = TP2_HALF_LO;
        end else if (reg_wdata[7:0] > TP2_HALF_HI) begin
          nxt_tp2_div = TP2_HALF_HI;
        end else begin
          nxt_tp2_div = reg_wdata[7:0];
        end
      end
    end
    // Strap defaults win over a write in the one load cycle
    if (strap_load) begin
      nxt_tp_sel = (strap_val[2:0] == STRAP_DEBUG) ? TP_SEL_DEBUG : TP_SEL_RST;
      nxt_mode   = strap_val[6:3];
    end
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        nxt_rdata = ctrl_ff;
      end else if (reg_addr == REG_TP_SEL) begin
        nxt_rdata = tp_sel_ff;
      end else if (reg_addr == REG_TP2_DIV) begin
        nxt_rdata = {8'h00, tp2_div_ff};
      end else if (reg_addr == REG_STATUS) begin
        nxt_rdata = {7'h00, strap_done, strap_val};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff      <= CTRL_RST;
      tp_sel_ff    <= TP_SEL_RST;
      tp2_div_ff   <= TP2_HALF_HI;
      rdata_ff     <= 16'h0000;
      done_seen_ff <= 1'b0;
      mode_ff      <= 4'h0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      tp_sel_ff    <= nxt_tp_sel;
      tp2_div_ff   <= nxt_tp2_div;
      rdata_ff     <= nxt_rdata;
      done_seen_ff <= nxt_done_seen;
      mode_ff      <= nxt_mode;
    end
  end

  // ----------------------------------------------------------------
  // Flash pins
  // ----------------------------------------------------------------
  // Order: clock, data, primary select, secondary select
  always_comb begin
    nxt_fl_out  = {flash_sel1_core, flash_sel0_core, flash_out_core, flash_clk_core};
    nxt_fl_oe_n = 4'h0;
  end

  // Reset floats three pins so a programmer can own the flash
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fl_out_ff  <= 4'h8;  // Secondary select held deselected
      fl_oe_n_ff <= 4'h7;  // Secondary select still driven
    end else begin
      fl_out_ff  <= nxt_fl_out;
      fl_oe_n_ff <= nxt_fl_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Array link
  // ----------------------------------------------------------------
  // Link clock is sampled; any change is a data edge, rises pace control
  assign hs_edge = lk_s2_ff ^ lk_s3_ff;
  assign ls_rise = lk_s2_ff & ~lk_s3_ff;

  always_comb begin
    nxt_lane_p = lane_p_ff;
    nxt_lane_n = lane_n_ff;
    nxt_hs_clk = hs_clk_ff;
    nxt_ctl    = ctl_ff;
    if (hs_edge) begin
      nxt_hs_clk = lk_s2_ff;
      for (int i = 0; i < NUM_LANES; i++) begin
        if (3'(i) < lane_lim) begin
          nxt_lane_p[i] = fast_write_lane_pair_p[lane_src(swap_code, 2'(i))];
          nxt_lane_n[i] = fast_write_lane_pair_n[lane_src(swap_code, 2'(i))];
        end else begin
          nxt_lane_p[i] = 1'b0;  // Unused lane idles
          nxt_lane_n[i] = 1'b0;
        end
      end
    end
    if (ls_rise) begin
      nxt_ctl = array_ctl_core;  // Single rate control path
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lk_s1_ff  <= 1'b0;
      lk_s2_ff  <= 1'b0;
      lk_s3_ff  <= 1'b0;
      lane_p_ff <= 4'h0;
      lane_n_ff <= 4'h0;
      hs_clk_ff <= 1'b0;
      ctl_ff    <= 1'b0;
    end else begin
      lk_s1_ff  <= array_link_clk;
      lk_s2_ff  <= lk_s1_ff;
      lk_s3_ff  <= lk_s2_ff;
      lane_p_ff <= nxt_lane_p;
      lane_n_ff <= nxt_lane_n;
      hs_clk_ff <= nxt_hs_clk;
      ctl_ff    <= nxt_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Test point outputs
  // ----------------------------------------------------------------
  // Dividers for points 0, 1, 2 and 7; fast rates clamp to one cycle
  assign div_half[0] = TP0_HALF;
  assign div_half[1] = TP1_HALF;
  assign div_half[2] = tp2_div_ff;
  assign div_half[3] = TP7_HALF;
  assign func_lvl    = {div_ph_ff[3], 4'b1101, div_ph_ff[2:0]};

  always_comb begin
    nxt_div_ph = div_ph_ff;
    for (int d = 0; d < 4; d++) begin
      if (div_cnt_ff[d] + 8'd1 >= div_half[d]) begin
        nxt_div_cnt[d] = 8'h00;
        nxt_div_ph[d]  = ~div_ph_ff[d];
      end else begin
        nxt_div_cnt[d] = div_cnt_ff[d] + 8'd1;
      end
    end
    // Pins stay inputs until the straps have been taken
    for (int t = 0; t < NUM_TP; t++) begin
      nxt_tp_o[t]    = 1'b0;
      nxt_tp_oe_n[t] = 1'b1;
      if (done_seen_ff && tp_sel_ff[2*t +: 2] != TP_FLOAT) begin
        nxt_tp_oe_n[t] = 1'b0;
        case (tp_sel_ff[2*t +: 2])
          TP_FUNC: nxt_tp_o[t] = func_lvl[t];
          TP_HIGH: nxt_tp_o[t] = 1'b1;
          default: nxt_tp_o[t] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < 4; d++) begin
        div_cnt_ff[d] <= 8'h00;
      end
      div_ph_ff  <= 4'h0;
      tp_o_ff    <= 8'h00;
      tp_oe_n_ff <= 8'hFF;
    end else begin
      for (int d = 0; d < 4; d++) begin
        div_cnt_ff[d] <= nxt_div_cnt[d];
      end
      div_ph_ff  <= nxt_div_ph;
      tp_o_ff    <= nxt_tp_o;
      tp_oe_n_ff <= nxt_tp_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                   = rdata_ff;
  assign flash_serial_clock_o        = fl_out_ff[0];
  assign flash_serial_out_o          = fl_out_ff[1];
  assign flash_select_primary_o      = fl_out_ff[2];
  assign flash_select_secondary_o    = fl_out_ff[3];
  assign flash_serial_clock_oe_n     = fl_oe_n_ff[0];
  assign flash_serial_out_oe_n       = fl_oe_n_ff[1];
  assign flash_select_primary_oe_n   = fl_oe_n_ff[2];
  assign flash_select_secondary_oe_n = fl_oe_n_ff[3];
  assign test_point_bus_o            = tp_o_ff;
  assign test_point_bus_oe_n         = tp_oe_n_ff;
  assign mode_option                 = mode_ff;
  assign mirror_array_lane_p         = lane_p_ff;
  assign mirror_array_lane_n         = lane_n_ff;
  assign mirror_array_hs_clk         = hs_clk_ff;
  assign mirror_array_ctl            = ctl_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Expected lane 0 source, sampled by the checks below
  assign exp_p0 = fast_write_lane_pair_p[lane_src(swap_code, 2'd0)];
  assign exp_n0 = fast_write_lane_pair_n[lane_src(swap_code, 2'd0)];

  AST_FLASH_FLOAT: assert property (@(posedge clk_sys)
    (!resetn ##1 !resetn) |-> (fl_oe_n_ff[2:0] == 3'h7))
    else $error("flash pins driven during reset");
  AST_SEL1_DRIVEN: assert property (@(posedge clk_sys)
    (!resetn ##1 !resetn) |-> (!fl_oe_n_ff[3]))
    else $error("secondary select released during reset");

  AST_SWAP_P: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (hs_edge && lane_lim != 3'd0) |=> (lane_p_ff[0] == $past(exp_p0)))
    else $error("lane 0 positive leg not from swap source");

  AST_SWAP_N: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (hs_edge && lane_lim != 3'd0) |=> (lane_n_ff[0] == $past(exp_n0)))
    else $error("lane 0 negative leg split from its pair");

  AST_LANE_IDLE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (hs_edge && lane_lim < 3'd4) |=> (!lane_p_ff[3] && !lane_n_ff[3]))
    else $error("unused lane driven");

  AST_LS_SDR: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (hs_edge && !ls_rise) |=> ($stable(ctl_ff) && !hs_clk_ff))
    else $error("control path moved on a falling link edge");

  AST_TP_INPUT: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !done_seen_ff |=> (tp_oe_n_ff == 8'hFF))
    else $error("test point driven before strap capture");

  AST_TP_QUIET: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ($rose(strap_done) && strap_val[2:0] == STRAP_QUIET && !reg_wr)
      |-> ##2 (tp_oe_n_ff == 8'hFF))
    else $error("quiet strap drove a test point");

  AST_TP_DEBUG: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ($rose(strap_done) && strap_val[2:0] == STRAP_DEBUG && !reg_wr)
      |-> ##2 (tp_oe_n_ff == 8'h00 && tp_o_ff[6:3] == 4'b1101))
    else $error("debug strap levels wrong");

  AST_TP_SW: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_wr && reg_addr == REG_TP_SEL && done_seen_ff)
      |=> (tp_sel_ff == $past(reg_wdata)))
    else $error("test point selection write lost");

  AST_MODE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(strap_done) |=> (mode_ff == strap_val[6:3]))
    else $error("mode option not taken from straps");

endmodule

//--- bench/rsm_array_model.sv
// Far side model: mirror array link clock, strap pull resistors, flash programmer
`timescale 1ns/1ps
module rsm_array_model (
  // Link control
  input  wire logic       link_run,
  output logic            array_link_clk,
  // Test point wires
  input  wire logic [7:0] strap_pullup,
  input  wire logic [7:0] tp_o,
  input  wire logic [7:0] tp_oe_n,
  output logic      [7:0] tp_level,
  // Flash pins seen by the programmer
  input  wire logic       resetn,
  input  wire logic [2:0] flash_oe_n,
  output logic            clash
);
  initial begin
    array_link_clk = 1'b0;
  end

  // Link clock only runs within frames; it stands still otherwise
  always begin
    #400;
    if (link_run) begin
      array_link_clk = ~array_link_clk;
    end
  end

  // Any clock, data or primary select driver enabled while the programmer drives is a fight
  assign clash = !resetn && (flash_oe_n != 3'h7);

  // Released test points fall to the internal pulldown unless pulled up
  assign tp_level = (~tp_oe_n & tp_o) | (tp_oe_n & strap_pullup);
endmodule

//--- bench/rsm_pin_mux_tb.sv
// Self-checking bench for flash release, strap capture, test points and lane swap
`timescale 1ns/1ps
module rsm_pin_mux_tb;
  import rsm_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, pull = 8'h00, pp = 8'h00, pn = 8'hFF;
  logic [7:0]  tp_o, tp_oe_n, tp_lvl, smp;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [3:0]  fl_core = 4'h0, mode, lane_p, lane_n;
  logic [2:0]  fl_oe_n;
  logic        fl_ck, fl_do, fl_s0, fl_s1, fl_s1_n, ctl, hs_clk, link_clk, clash;
  logic        ctl_core = 1'b0, link_run = 1'b0;
  logic [11:0] swap_tbl [4] = '{12'h953, 12'h077, 12'h6AC, 12'hF88}; // DCFE HGBA EFCD ABGH
  int          bad_count = 0, cmp_count = 0, cyc = 0;

  always #50 clk_sys = ~clk_sys;

  rsm_pin_mux rsm_pin_mux_inst (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_clk_core(fl_core[3]), .flash_out_core(fl_core[2]),
    .flash_sel0_core(fl_core[1]), .flash_sel1_core(fl_core[0]),
    .flash_serial_clock_o(fl_ck), .flash_serial_clock_oe_n(fl_oe_n[2]),
    .flash_serial_out_o(fl_do), .flash_serial_out_oe_n(fl_oe_n[1]),
    .flash_select_primary_o(fl_s0), .flash_select_primary_oe_n(fl_oe_n[0]),
    .flash_select_secondary_o(fl_s1), .flash_select_secondary_oe_n(fl_s1_n),
    .test_point_bus_i(tp_lvl), .test_point_bus_o(tp_o), .test_point_bus_oe_n(tp_oe_n),
    .mode_option(mode), .fast_write_lane_pair_p(pp), .fast_write_lane_pair_n(pn),
    .array_ctl_core(ctl_core), .array_link_clk(link_clk), .mirror_array_lane_p(lane_p),
    .mirror_array_lane_n(lane_n), .mirror_array_hs_clk(hs_clk), .mirror_array_ctl(ctl));

  rsm_array_model rsm_array_model_inst (
    .link_run(link_run), .array_link_clk(link_clk), .strap_pullup(pull), .tp_o(tp_o),
    .tp_oe_n(tp_oe_n), .tp_level(tp_lvl), .resetn(resetn), .flash_oe_n(fl_oe_n),
    .clash(clash));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rdc(input logic [7:0] a, input string what, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset(input logic [7:0] straps);
    @(posedge clk_sys);
    resetn <= 1'b0;
    pull <= straps;
    settle(6);
    chk("flash oe_n", 16'(fl_oe_n), 16'h0007);
    chk("sel1 pin", 16'({fl_s1_n, fl_s1}), 16'h0001);
    chk("programmer clash", 16'(clash), 16'h0000);
    chk("tp oe_n in reset", 16'(tp_oe_n), 16'h00FF);
    @(posedge clk_sys);
    resetn <= 1'b1;
    fl_core <= fl_core + 4'h5;
    settle(8);
    chk("mode option", 16'(mode), 16'(straps[6:3]));
    chk("flash pins", 16'({fl_oe_n, fl_ck, fl_do, fl_s0, fl_s1}), 16'(fl_core));
  endtask

  // Each one-hot pair must land whole on the lanes its code names
  task automatic lane_test(input logic [3:0] code);
    logic [3:0] ep;
    wr(REG_CTRL, 16'h0040 | 16'(code));
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys);
      pp <= 8'(1 << s);
      pn <= ~8'(1 << s);
      settle(12);
      for (int i = 0; i < 4; i++) begin
        ep[i] = (swap_tbl[code[1:0]][i*3 +: 3] == 3'(s));
      end
      chk("lanes", 16'({lane_n, lane_p}), 16'({~ep, ep}));
    end
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset(8'h00);
    chk("tp quiet", 16'(tp_oe_n), 16'h00FF);
    rdc(REG_STATUS, "status", 16'h0100);
    rdc(REG_CTRL, "ctrl reset", 16'h0040);
    rdc(REG_TP2_DIV, "div reset", 16'h0007);
    wr(REG_CTRL, 16'hFFFF);
    rdc(REG_CTRL, "ctrl mask", 16'h007F);
    wr(REG_STATUS, 16'h00FF);
    rdc(REG_STATUS, "status ro", 16'h0100);
    rdc(8'h10, "unmapped", 16'h0000);
    @(posedge clk_sys) pull <= 8'h07;
    settle(4);
    rdc(REG_STATUS, "status held", 16'h0100);
    chk("tp still quiet", 16'(tp_oe_n), 16'h00FF);
    $display("test quiet strap done");

    do_reset(8'h2A);
    rdc(REG_STATUS, "status debug", 16'h012A);
    rdc(REG_TP_SEL, "tp sel default", 16'h5555);
    chk("tp driven", 16'(tp_oe_n), 16'h0000);
    chk("tp levels", 16'(tp_lvl[6:3]), 16'h000D);
    wr(REG_TP2_DIV, 16'h0001);
    settle(3);
    smp = tp_o;
    settle(1);
    chk("tp clocks", 16'(tp_o ^ smp), 16'h0087);
    @(posedge clk_sys) pull <= 8'h00;
    settle(4);
    rdc(REG_STATUS, "status after pins", 16'h012A);
    wr(REG_TP_SEL, 16'hAAAA);
    settle(2);
    chk("tp all low", 16'({tp_oe_n, tp_o}), 16'h0000);
    wr(REG_TP_SEL, 16'hFFFF);
    settle(2);
    chk("tp all high", 16'({tp_oe_n, tp_o}), 16'h00FF);
    wr(REG_TP_SEL, 16'h0000);
    settle(2);
    chk("tp floated", 16'(tp_oe_n), 16'h00FF);
    $display("test debug strap done");

    @(posedge clk_sys) link_run <= 1'b1;
    lane_test(4'h0);
    lane_test(4'h2);
    lane_test(4'h1);
    lane_test(4'h3);
    lane_test(4'hE);
    @(posedge clk_sys) ctl_core <= 1'b1;
    settle(12);
    chk("ctl path", 16'(ctl), 16'h0001);
    smp = 8'h00;
    for (int k = 0; k < 12; k++) begin
      settle(1);
      smp[hs_clk] = 1'b1;
    end
    chk("hs clock moves", 16'(smp), 16'h0003);
    wr(REG_CTRL, 16'h0020);
    pp <= 8'hFF;
    pn <= 8'hFF;
    settle(12);
    chk("two lanes", 16'({lane_n, lane_p}), 16'h0033);
    @(posedge clk_sys) link_run <= 1'b0;
    $display("test lane swap done");
    end_of_test();
  end
endmodule
